// ---- inc/csf_pkg.sv ----
// Functional notes
// (RL1) status bits 7..5 hold a 3-bit priority level; 111 blocks user interrupts.
// (RL2) core control bit 3 prefixes the level; one means levels 8..15, users off.
// (RL3) with the nesting-off bit set, software writes to the priority field are ignored.
// (RL4) bit 4 is set while a loop runs and clear otherwise.
// (RL5) bit 3 is set for a negative result, cleared otherwise.
// (RL6) bit 2 is set on signed overflow, cleared otherwise.
// (RL7) bit 1 is a sticky zero, cleared only by a non-zero zero-affecting result; the code instead sets it on every zero result of an alu command.
// (RL8) bit 0 is set on carry out of the msb, cleared otherwise.
// (RL9) a status write sets both clip flags directly or clears both via the combined bit.
// (RL10) software should not change the clip flags with single-bit read-modify-write.
// (RL11) unaffected flags hold; affected flags update in the result's cycle.
package csf_pkg;
   localparam logic [11:0] CSF_STATUS_OFFSET = 12'h000;
   localparam logic [11:0] CSF_CORE_CTRL_OFFSET = 12'h004;
   localparam logic [11:0] CSF_INT_CTRL_OFFSET = 12'h008;
   localparam logic [11:0] CSF_ALU_OFFSET = 12'h00C;
   localparam logic [11:0] CSF_ALU_CMD_OFFSET = 12'h010;
   localparam int CSF_BIT_CARRY = 0;
   localparam int CSF_BIT_ZERO = 1;
   localparam int CSF_BIT_WRAP = 2;
   localparam int CSF_BIT_NEG = 3;
   localparam int CSF_BIT_LOOP = 4;
   localparam int CSF_IPL_LSB = 5;
   localparam int CSF_IPL_MSB = 7;
   localparam int CSF_BIT_CLIPAB = 8;
   localparam int CSF_BIT_CLIPB = 9;
   localparam int CSF_BIT_CLIPA = 10;
   localparam int CSF_CORE_IPL3 = 3;
   localparam int CSF_NEST_OFF = 15;
   localparam logic [2:0] CSF_IPL_BLOCK = 3'h7;
   localparam logic [15:0] CSF_STATUS_RESET = 16'h0000;
   localparam logic [15:0] CSF_CTRL_RESET = 16'h0000;
   typedef enum logic [1:0] {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_AND, CSF_OP_MOVE} csf_op_t;
endpackage

// ---- sim/cpu_status_flags_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flags_tb_top;
   import csf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, loop_active, clip_a_set, clip_b_set, pready, pslverr;
   logic user_irq_blocked, loop_busy_flag, x;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] cpu_priority_level;
   logic [3:0] pstrb;
   logic [15:0] alu_result;
   int error_cnt, checks_done, cyc;
   logic [15:0] ta [6] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h1234, 16'h0000, 16'h8000};
   logic [15:0] tb [6] = '{16'h0001, 16'hFFFF, 16'h0001, 16'h8000, 16'h0001, 16'h0001};
   logic [1:0] top [6] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1};
   logic [15:0] tres [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF};
   logic [15:0] tst [6] = '{16'h000C, 16'h0006, 16'h0003, 16'h0009, 16'h0008, 16'h0005};
   csf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .loop_active(loop_active), .clip_a_set(clip_a_set), .clip_b_set(clip_b_set),
      .cpu_priority_level(cpu_priority_level), .user_irq_blocked(user_irq_blocked),
      .loop_busy_flag(loop_busy_flag), .alu_result(alu_result));
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   // request held until the rising edge that samples pready high; data taken and request released there
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      x = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000, 4'h0);
      chk("read", e, q);
   endtask
   task automatic st(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic lvl(input logic [3:0] l, input logic b);
      st(2);
      chk("level", {28'h0, l}, {28'h0, cpu_priority_level});
      chk("blocked", {31'h0, b}, {31'h0, user_irq_blocked});
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, loop_active, clip_a_set, clip_b_set} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rc(12'h000, 32'h00000000);
      for (int i = 0; i < 6; i++) begin
         wr(12'h00C, {tb[i], ta[i]});
         wr(12'h010, {30'h0, top[i]});
         st(1);
         chk("alu_result", {16'h0, tres[i]}, {16'h0, alu_result});
         rc(12'h000, {16'h0, tst[i]});
      end
      wr(12'h000, 32'h000000A0);
      lvl(4'h5, 1'b0);
      wr(12'h004, 32'h00000008);
      lvl(4'hD, 1'b1);
      wr(12'h004, 32'h00000000);
      wr(12'h000, 32'h000000E0);
      lvl(4'h7, 1'b1);
      wr(12'h008, 32'h00008000);
      wr(12'h000, 32'h00000020);
      lvl(4'h7, 1'b1);
      wr(12'h008, 32'h00000000);
      wr(12'h000, 32'h00000000);
      lvl(4'h0, 1'b0);
      @(posedge pclk) loop_active <= 1'b1;
      st(3);
      chk("loop_busy_flag", 32'h1, {31'h0, loop_busy_flag});
      wr(12'h000, 32'h00000000);
      rc(12'h000, 32'h00000010);
      @(posedge pclk) loop_active <= 1'b0;
      st(3);
      rc(12'h000, 32'h00000000);
      @(posedge pclk) clip_a_set <= 1'b1;
      @(posedge pclk) clip_a_set <= 1'b0;
      rc(12'h000, 32'h00000500);
      @(posedge pclk) clip_b_set <= 1'b1;
      @(posedge pclk) clip_b_set <= 1'b0;
      rc(12'h000, 32'h00000700);
      wr(12'h000, 32'h00000000);
      rc(12'h000, 32'h00000000);
      wr(12'h000, 32'h00000300);
      rc(12'h000, 32'h00000300);
      apb(1'b1, 12'h000, 32'h000000E0, 4'h1);
      rc(12'h000, 32'h000003E0);
      apb(1'b1, 12'h000, 32'h00000000, 4'h2);
      rc(12'h000, 32'h000000E0);
      rc(12'h014, 32'h00000000);
      chk("pslverr", 32'h1, {31'h0, x});
      complete_run();
   end
endmodule
`default_nettype wire

// ---- sim/csf_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module csf_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic loop_active,
   input wire logic [3:0] cpu_priority_level,
   input wire logic user_irq_blocked,
   input wire logic loop_busy_flag,
   input wire logic [15:0] alu_result
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable && pready && pwrite && !pslverr;
   wire logic w_st = acc && paddr == 12'h000;
   wire logic w_cc = acc && paddr == 12'h004;
   wire logic w_cmd = acc && paddr == 12'h010;
   a_block_level: assert property (user_irq_blocked == (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
      else $error("blocked flag disagrees with level");
   a_level_low_src: assert property ($changed(cpu_priority_level[2:0]) |-> $past(w_st, 2))
      else $error("level field moved without status write");
   a_level_hi_src: assert property ($changed(cpu_priority_level[3]) |-> $past(w_cc, 2))
      else $error("level prefix moved without core control write");
   a_loop_follow: assert property ($past(presetn, 2) |-> loop_busy_flag == $past(loop_active, 2))
      else $error("loop flag does not follow loop input");
   a_alu_src: assert property ($changed(alu_result) |-> $past(w_cmd))
      else $error("alu result moved without command");
   a_err_map: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
      else $error("slave error on wrong address");
   a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("read data not zero on error");
   a_one_access: assert property (pready |-> psel && penable && $past(psel && !penable) ##1 !pready)
      else $error("ready outside single access cycle");
   c_cmd: cover property (w_cmd);
   c_loop: cover property (loop_busy_flag);
   c_block: cover property (user_irq_blocked && !cpu_priority_level[3]);
endmodule
bind csf_top csf_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_active(loop_active),
   .cpu_priority_level(cpu_priority_level), .user_irq_blocked(user_irq_blocked), .loop_busy_flag(loop_busy_flag),
   .alu_result(alu_result));
`default_nettype wire

// ---- src/csf_alu.sv ----
`timescale 1ns/10ps
`default_nettype none
module csf_alu
   import csf_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] a,
   input wire logic [WIDTH-1:0] b,
   input wire csf_pkg::csf_op_t op,
   output logic [WIDTH-1:0] result,
   output logic neg,
   output logic wrap,
   output logic zero,
   output logic carry
);
   logic [WIDTH:0] sum;
   // sign and carry taps need at least two bits
   if (WIDTH < 2) begin : g_width_check
      $error("width too small");
   end
   always_comb begin
      sum = '0;
      wrap = 1'b0;
      case (op)
         CSF_OP_ADD: begin
            sum = {1'b0, a} + {1'b0, b};
            wrap = (a[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]); // [RL6]
         end
         CSF_OP_SUB: begin
            // carry is inverted borrow, as with a + ~b + 1
            sum = {1'b0, a} + {1'b0, ~b} + {{WIDTH{1'b0}}, 1'b1};
            wrap = (a[WIDTH-1] != b[WIDTH-1]) && (sum[WIDTH-1] != a[WIDTH-1]); // [RL6]
         end
         CSF_OP_AND: sum = {1'b0, a & b};
         default: sum = {1'b0, b};
      endcase
      result = sum[WIDTH-1:0];
      neg = sum[WIDTH-1]; // [RL5]
      zero = (sum[WIDTH-1:0] == '0);
      carry = sum[WIDTH]; // [RL8]
   end
endmodule
`default_nettype wire

// ---- src/csf_top.sv ----
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module csf_top
   import csf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic loop_active,
   input wire logic clip_a_set,
   input wire logic clip_b_set,
   output logic [3:0] cpu_priority_level,
   output logic user_irq_blocked,
   output logic loop_busy_flag,
   output logic [15:0] alu_result
);
   import csf_pkg::*;

   // status is kept as one register per concern and assembled below, so no bit has two drivers
   logic [2:0] ipl_field;
   logic loop_bit;
   logic [3:0] alu_flags;
   logic clip_a;
   logic clip_b;
   logic [15:0] status;
   logic [15:0] core_control_reg;
   logic [15:0] interrupt_control_one;
   logic [15:0] op_a;
   logic [15:0] op_b;
   logic [15:0] res;
   logic neg;
   logic wrap;
   logic zero;
   logic carry;
   logic setup_phase;
   logic wr;
   logic rd;
   logic hit;
   logic sel_status;
   logic sel_core;
   logic sel_int;
   logic sel_alu;
   logic sel_cmd;
   logic status_wr_lo;
   logic status_wr_hi;
   logic ipl_wr;
   logic alu_go;
   logic arith_op;
   csf_op_t alu_op;
   logic [1:0] op_sel;
   logic clip_ab_clear;
   logic clip_direct;
   logic [31:0] next_prdata;

   // access decode
   assign setup_phase = psel && !penable;
   assign wr = psel && penable && pwrite && pready;
   assign rd = setup_phase && !pwrite;
   assign sel_status = (paddr == CSF_STATUS_OFFSET);
   assign sel_core = (paddr == CSF_CORE_CTRL_OFFSET);
   assign sel_int = (paddr == CSF_INT_CTRL_OFFSET);
   assign sel_alu = (paddr == CSF_ALU_OFFSET);
   assign sel_cmd = (paddr == CSF_ALU_CMD_OFFSET);
   assign hit = sel_status || sel_core || sel_int || sel_alu || sel_cmd;
   assign status_wr_lo = wr && sel_status && pstrb[0];
   assign status_wr_hi = wr && sel_status && pstrb[1];
   // only software writes are frozen; the level has no other source in this block
   assign ipl_wr = status_wr_lo && !interrupt_control_one[CSF_NEST_OFF]; // [RL3]
   assign alu_go = wr && sel_cmd && pstrb[0];
   assign op_sel = pwdata[1:0];
   assign alu_op = csf_op_t'(op_sel);
   assign arith_op = (alu_op == CSF_OP_ADD) || (alu_op == CSF_OP_SUB);
   // a cleared combined bit clears the pair; a set one lets bits 10 and 9 be written
   assign clip_ab_clear = status_wr_hi && !pwdata[CSF_BIT_CLIPAB]; // [RL9]
   assign clip_direct = status_wr_hi && pwdata[CSF_BIT_CLIPAB]; // [RL9]

   // combined clip bit mirrors the pair; upper bits unused
   assign status = {5'h00, clip_a, clip_b, clip_a | clip_b, ipl_field, loop_bit, alu_flags};

   csf_alu #(.WIDTH(16)) u_alu (
      .a(op_a),
      .b(op_b),
      .op(alu_op),
      .result(res),
      .neg(neg),
      .wrap(wrap),
      .zero(zero),
      .carry(carry)
   );

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (sel_status) begin
         next_prdata = {16'h0000, status};
      end else if (sel_core) begin
         next_prdata = {16'h0000, core_control_reg};
      end else if (sel_int) begin
         next_prdata = {16'h0000, interrupt_control_one};
      end else if (sel_alu) begin
         next_prdata = {op_b, op_a};
      end
   end

   // single-cycle apb slave, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase && !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         prdata <= next_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_control_reg <= CSF_CTRL_RESET;
      end else if (wr && sel_core) begin
         if (pstrb[0]) begin
            core_control_reg[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            core_control_reg[15:8] <= pwdata[15:8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_control_one <= CSF_CTRL_RESET;
      end else if (wr && sel_int) begin
         if (pstrb[0]) begin
            interrupt_control_one[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            interrupt_control_one[15:8] <= pwdata[15:8];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_a <= 16'h0000;
         op_b <= 16'h0000;
      end else if (wr && sel_alu) begin
         if (pstrb[0]) begin
            op_a[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            op_a[15:8] <= pwdata[15:8];
         end
         if (pstrb[2]) begin
            op_b[7:0] <= pwdata[23:16];
         end
         if (pstrb[3]) begin
            op_b[15:8] <= pwdata[31:24];
         end
      end
   end

   // priority field, software writable unless nesting is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ipl_field <= CSF_STATUS_RESET[CSF_IPL_MSB:CSF_IPL_LSB];
      end else if (ipl_wr) begin // [RL3]
         ipl_field <= pwdata[CSF_IPL_MSB:CSF_IPL_LSB]; // [RL1]
      end
   end

   // loop flag follows the loop sequencer, read-only to software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_bit <= CSF_STATUS_RESET[CSF_BIT_LOOP];
      end else begin
         loop_bit <= loop_active; // [RL4]
      end
   end

   // alu flags: an alu command wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_flags <= CSF_STATUS_RESET[CSF_BIT_NEG:CSF_BIT_CARRY];
      end else if (alu_go) begin
         alu_flags[CSF_BIT_NEG] <= neg; // [RL5]
         alu_flags[CSF_BIT_ZERO] <= zero; // [RL7]
         if (arith_op) begin // [RL11]
            alu_flags[CSF_BIT_WRAP] <= wrap; // [RL6]
            alu_flags[CSF_BIT_CARRY] <= carry; // [RL8]
         end
      end else if (status_wr_lo) begin
         alu_flags <= pwdata[CSF_BIT_NEG:CSF_BIT_CARRY];
      end
   end

   // clip flags: hardware set wins over a software clear, so no saturation event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clip_a <= CSF_STATUS_RESET[CSF_BIT_CLIPA];
      end else if (clip_a_set) begin
         clip_a <= 1'b1;
      end else if (clip_ab_clear) begin
         clip_a <= 1'b0; // [RL9]
      end else if (clip_direct) begin
         clip_a <= pwdata[CSF_BIT_CLIPA]; // [RL9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clip_b <= CSF_STATUS_RESET[CSF_BIT_CLIPB];
      end else if (clip_b_set) begin
         clip_b <= 1'b1;
      end else if (clip_ab_clear) begin
         clip_b <= 1'b0; // [RL9]
      end else if (clip_direct) begin
         clip_b <= pwdata[CSF_BIT_CLIPB]; // [RL9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_priority_level <= 4'h0;
         user_irq_blocked <= 1'b0;
         loop_busy_flag <= 1'b0;
      end else begin
         cpu_priority_level <= {core_control_reg[CSF_CORE_IPL3], ipl_field}; // [RL2]
         user_irq_blocked <= core_control_reg[CSF_CORE_IPL3] || (ipl_field == CSF_IPL_BLOCK); // [RL1] [RL2]
         loop_busy_flag <= loop_bit; // [RL4]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_result <= 16'h0000;
      end else if (alu_go) begin
         alu_result <= res; // [RL11]
      end
   end
endmodule
`default_nettype wire
